// ===== rtl/scp_config_port.sv
`timescale 1ns/100ps
module scp_config_port (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // serial port pins
  input wire logic sclk_pin,
  input wire logic sdata_pin,
  input wire logic latch_strobe,
  input wire logic chip_enable,
  // multiplexed pins: mux output, trigger one, trigger two, modulation
  input wire logic [scp_pkg::NUM_PINS-1:0] pin_in,
  output scp_pkg::scp_pins_s pins_ff,
  // core side
  input wire logic [scp_pkg::NUM_PINS-1:0] diag_in,
  input wire logic fastlock_active,
  output logic [scp_pkg::NUM_PINS-1:0] pin_func_ff,
  output logic [scp_pkg::NUM_REGS*scp_pkg::DATA_W-1:0] regs_ff
);

  logic [scp_pkg::SYNC_W-1:0] lvl;
  logic [scp_pkg::SYNC_W-1:0] rise;
  logic [scp_pkg::SYNC_W-1:0] fall;
  logic [scp_pkg::DATA_W-1:0] reg_mem [scp_pkg::NUM_REGS];
  logic [scp_pkg::FRAME_BITS-1:0] shift_ff;
  logic [scp_pkg::CNT_W-1:0] cnt_ff;
  scp_pkg::scp_phase_e phase_ff;
  logic read_ff;
  logic [scp_pkg::ADDR_W-1:0] addr_ff;
  logic [scp_pkg::DATA_W-1:0] held_ff;
  logic held_vld_ff;
  logic [scp_pkg::DATA_W-1:0] rb_ff;
  logic sclk_up;
  logic sclk_dn;
  logic latch_up;
  logic [scp_pkg::CNT_W-1:0] nxt_cnt;
  logic [scp_pkg::FRAME_BITS-1:0] nxt_shift;
  logic byte_done;
  logic commit;
  logic [scp_pkg::ADDR_W-1:0] commit_addr;

  // addresses beyond the file are ignored on write and read as zero
  function automatic logic [scp_pkg::DATA_W-1:0] rd_reg(input logic [scp_pkg::ADDR_W-1:0] a,
                                                          input logic [scp_pkg::DATA_W-1:0] m [scp_pkg::NUM_REGS]);
    if (a < scp_pkg::ADDR_W'(scp_pkg::NUM_REGS)) begin
      return m[a[scp_pkg::IDX_W-1:0]];
    end
    return '0;
  endfunction

  scp_sync_edge #(.W(scp_pkg::SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({pin_in, chip_enable, latch_strobe, sdata_pin, sclk_pin}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // ----------------------------------------------------------------
  // frame decode
  // ----------------------------------------------------------------
  // chip enable low blocks the serial clock and abandons any partial frame so a glitchy bus cannot disturb it
  assign sclk_up = rise[scp_pkg::SER_SCLK] & lvl[scp_pkg::SER_CE];
  assign sclk_dn = fall[scp_pkg::SER_SCLK] & lvl[scp_pkg::SER_CE];
  assign latch_up = rise[scp_pkg::SER_LATCH];
  assign nxt_cnt = cnt_ff + 5'h01;
  assign nxt_shift = {shift_ff[scp_pkg::FRAME_BITS-2:0], lvl[scp_pkg::SER_DATA]};
  assign byte_done = sclk_up && phase_ff == scp_pkg::PH_DATA && nxt_cnt == scp_pkg::CNT_FRAME;
  // a held byte is committed by the strobe, or by the next byte of a stream
  assign commit = held_vld_ff && !read_ff && (latch_up || byte_done);
  assign commit_addr = addr_ff;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      shift_ff <= '0;
    end else if (sclk_up) begin
      shift_ff <= nxt_shift;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || latch_up || !lvl[scp_pkg::SER_CE]) begin
      cnt_ff <= '0;
      phase_ff <= scp_pkg::PH_HEADER;
      read_ff <= 1'b0;
    end else if (sclk_up) begin
      unique case (phase_ff)
        scp_pkg::PH_HEADER: begin
          cnt_ff <= nxt_cnt;
          if (nxt_cnt == scp_pkg::CNT_HDR) begin
            phase_ff <= scp_pkg::PH_DATA;
            read_ff <= nxt_shift[scp_pkg::RW_POS];
          end
        end
        scp_pkg::PH_DATA: begin
          // a full byte rewinds the count so the next byte starts a stream
          cnt_ff <= (nxt_cnt == scp_pkg::CNT_FRAME) ? scp_pkg::CNT_HDR : nxt_cnt;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr_ff <= '0;
    end else if (sclk_up && phase_ff == scp_pkg::PH_HEADER && nxt_cnt == scp_pkg::CNT_HDR) begin
      addr_ff <= nxt_shift[scp_pkg::ADDR_W-1:0];
    end else if (byte_done && (read_ff || held_vld_ff)) begin
      addr_ff <= addr_ff - 15'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || latch_up || !lvl[scp_pkg::SER_CE]) begin
      held_ff <= '0;
      held_vld_ff <= 1'b0;
    end else if (byte_done && !read_ff) begin
      held_ff <= nxt_shift[scp_pkg::DATA_W-1:0];
      held_vld_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
        reg_mem[i] <= scp_pkg::REG_RST;
      end
    end else if (commit && commit_addr < scp_pkg::ADDR_W'(scp_pkg::NUM_REGS)) begin
      reg_mem[commit_addr[scp_pkg::IDX_W-1:0]] <= held_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regs_ff <= '0;
    end else begin
      for (int i = 0; i < scp_pkg::NUM_REGS; i++) begin
        regs_ff[i*scp_pkg::DATA_W +: scp_pkg::DATA_W] <= reg_mem[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  // loaded on the falling edge so the host samples a settled bit late in the following high phase
  always_ff @(posedge sys_clk) begin
    if (srst || latch_up) begin
      rb_ff <= '0;
    end else if (sclk_dn && read_ff && cnt_ff == scp_pkg::CNT_HDR) begin
      rb_ff <= rd_reg(addr_ff, reg_mem);
    end else if (sclk_dn && read_ff) begin
      rb_ff <= {rb_ff[scp_pkg::DATA_W-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // multiplexed pins
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pins_ff <= '0;
      pin_func_ff <= '0;
    end else begin
      for (int i = 0; i < scp_pkg::NUM_PINS; i++) begin
        unique case (scp_pkg::scp_pin_mode_e'(reg_mem[i][1:0]))
          scp_pkg::PIN_INPUT: begin
            pins_ff.o[i] <= 1'b0;
            pins_ff.oe[i] <= 1'b0;
            pin_func_ff[i] <= lvl[scp_pkg::SER_CE + 1 + i];
          end
          scp_pkg::PIN_READBACK: begin
            pins_ff.o[i] <= rb_ff[scp_pkg::DATA_W-1];
            pins_ff.oe[i] <= 1'b1;
            pin_func_ff[i] <= 1'b0;
          end
          scp_pkg::PIN_DIAG: begin
            pins_ff.o[i] <= diag_in[i];
            pins_ff.oe[i] <= 1'b1;
            pin_func_ff[i] <= 1'b0;
          end
          scp_pkg::PIN_FASTLOCK: begin
            // inverted open drain: released normally, pulled low while fastlock runs
            pins_ff.o[i] <= 1'b0;
            pins_ff.oe[i] <= fastlock_active;
            pin_func_ff[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_shift_on_rise: assert property (@(posedge sys_clk) disable iff (srst)
    sclk_up |=> shift_ff[0] == $past(lvl[scp_pkg::SER_DATA]))
    else $error("serial bit not shifted on clock rise");

  a_latch_commit: assert property (@(posedge sys_clk) disable iff (srst)
    (latch_up && held_vld_ff && !read_ff && addr_ff < 15'h0020)
      |=> reg_mem[$past(addr_ff[4:0])] == $past(held_ff))
    else $error("latch strobe did not commit held byte");

  a_stream_down: assert property (@(posedge sys_clk) disable iff (srst)
    (byte_done && held_vld_ff && !read_ff) |=> addr_ff == $past(addr_ff) - 15'h0001)
    else $error("stream did not step to next lower register");

  a_read_load: assert property (@(posedge sys_clk) disable iff (srst)
    (sclk_dn && read_ff && cnt_ff == scp_pkg::CNT_HDR && !latch_up)
      |=> rb_ff == $past(rd_reg(addr_ff, reg_mem)))
    else $error("readback byte not loaded");

  a_read_pin: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_mem[0][1:0] == 2'h1) ##1 (reg_mem[0][1:0] == 2'h1)
      |-> pins_ff.oe[0] && pins_ff.o[0] == $past(rb_ff[7]))
    else $error("readback not on selected pin");

  a_input_release: assert property (@(posedge sys_clk) disable iff (srst)
    (reg_mem[1][1:0] == 2'h0) |=> !pins_ff.oe[1])
    else $error("input pin driven");

  a_header_len: assert property (@(posedge sys_clk) disable iff (srst)
    (sclk_up && !latch_up && phase_ff == scp_pkg::PH_HEADER && nxt_cnt == scp_pkg::CNT_HDR)
      |=> phase_ff == scp_pkg::PH_DATA && read_ff == $past(nxt_shift[scp_pkg::RW_POS])
        && addr_ff == $past(nxt_shift[scp_pkg::ADDR_W-1:0]))
    else $error("header not decoded after sixteen bits");

endmodule

// ===== rtl/scp_pkg.sv
package scp_pkg;

  // ----------------------------------------------------------------
  // frame layout: read flag, address, data, sent msb first
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int HDR_BITS = 16;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_HDR = 5'h10;
  localparam logic [CNT_W-1:0] CNT_FRAME = 5'h18;
  localparam int RW_POS = 15;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  localparam int NUM_REGS = 32;
  localparam int IDX_W = 5;
  localparam logic [DATA_W-1:0] REG_RST = 8'h00;
  localparam int NUM_PINS = 4;
  // registers 0..3 hold the mode of mux, trigger one, trigger two, modulation pin
  localparam logic [IDX_W-1:0] PIN_CFG_BASE = 5'h00;

  // ----------------------------------------------------------------
  // sampled inputs
  // ----------------------------------------------------------------
  localparam int SER_SCLK = 0;
  localparam int SER_DATA = 1;
  localparam int SER_LATCH = 2;
  localparam int SER_CE = 3;
  localparam int SYNC_W = 8;

  typedef enum logic [1:0] {
    PIN_INPUT = 2'h0,
    PIN_READBACK = 2'h1,
    PIN_DIAG = 2'h2,
    PIN_FASTLOCK = 2'h3
  } scp_pin_mode_e;

  typedef enum {
    PH_HEADER,
    PH_DATA
  } scp_phase_e;

  typedef struct packed {
    logic [NUM_PINS-1:0] o;
    logic [NUM_PINS-1:0] oe;
  } scp_pins_s;

endpackage

// ===== rtl/scp_sync_edge.sv
`timescale 1ns/100ps
module scp_sync_edge #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // asynchronous inputs
  input wire logic [W-1:0] async_in,
  // synchronised level and edges
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] prev_ff;

  // first stage is read only by the second stage
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = sync_ff & ~prev_ff;
  assign fall = ~sync_ff & prev_ff;

endmodule

// ===== test/scp_host_model.sv
`timescale 1ns/100ps
module scp_host_model (
  // clock
  input wire logic sys_clk,
  // serial lines to the device
  output logic sclk_pin,
  output logic sdata_pin,
  output logic latch_strobe,
  output logic chip_enable,
  // resolved multiplexed pins
  input wire logic [3:0] pin_wire
);
  logic [15:0] rb = 16'h0000;
  initial begin
    sclk_pin = 1'b0;
    sdata_pin = 1'b0;
    latch_strobe = 1'b0;
    chip_enable = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge sys_clk);
  endtask
  // readback taken late in the high phase, clear of the device update after each fall
  task automatic shift(input logic [39:0] b, input int n, input bit le, input int p);
    for (int i = n - 1; i >= 0; i--) begin
      sdata_pin <= b[i];
      half();
      sclk_pin <= 1'b1;
      half();
      rb <= {rb[14:0], pin_wire[p]};
      sclk_pin <= 1'b0;
    end
    half();
    latch_strobe <= le;
    half();
    latch_strobe <= 1'b0;
    // a released data line must not keep showing its last bit
    sdata_pin <= ~sdata_pin;
    half();
  endtask
  task automatic drop_ce();
    chip_enable <= 1'b0;
    repeat (130) @(posedge sys_clk);
    chip_enable <= 1'b1;
    half();
  endtask
endmodule

// ===== test/tb_serial_config_port.sv
`timescale 1ns/100ps
module tb_serial_config_port;
  typedef struct {int sel; logic [7:0] v;} scp_note_s;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic fastlock_active = 1'b0;
  logic [3:0] ext_in = 4'h0;
  logic [3:0] diag_in = 4'h0;
  logic sclk_pin, sdata_pin, latch_strobe, chip_enable;
  logic [3:0] pin_wire, pin_func_ff;
  logic [255:0] regs_ff;
  scp_pkg::scp_pins_s pins_ff;
  logic [7:0] mirror [32];
  scp_note_s notes [$];
  int err_total = 0;
  int n_tests = 0;
  event settle;

  always #20 sys_clk = ~sys_clk;
  // an undriven pin reads the external level
  assign pin_wire = (pins_ff.oe & pins_ff.o) | (~pins_ff.oe & ext_in);

  scp_config_port dut (.sys_clk(sys_clk), .srst(srst), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin),
    .latch_strobe(latch_strobe), .chip_enable(chip_enable), .pin_in(pin_wire), .pins_ff(pins_ff),
    .diag_in(diag_in), .fastlock_active(fastlock_active), .pin_func_ff(pin_func_ff), .regs_ff(regs_ff));
  scp_host_model host (.sys_clk(sys_clk), .sclk_pin(sclk_pin), .sdata_pin(sdata_pin),
    .latch_strobe(latch_strobe), .chip_enable(chip_enable), .pin_wire(pin_wire));

  task automatic check(input int sel, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: item %0d seen %h expected %h", $time, sel, seen, exp);
    end
  endtask

  always begin
    scp_note_s n;
    @(settle);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      case (n.sel)
        32: check(n.sel, host.rb[15:8], n.v);
        33: check(n.sel, host.rb[7:0], n.v);
        34: check(n.sel, pins_ff, n.v);
        35: check(n.sel, {4'h0, pin_func_ff}, n.v);
        default: check(n.sel, regs_ff[n.sel*8+:8], n.v);
      endcase
    end
  end

  function automatic logic [7:0] mval(input logic [14:0] a);
    return (a < 15'h0020) ? mirror[a[4:0]] : 8'h00;
  endfunction

  task automatic expect_all();
    logic [3:0] o, oe, fn;
    for (int p = 0; p < 4; p++) begin
      case (mirror[p][1:0])
        2'h0: {o[p], oe[p], fn[p]} = {2'b00, ext_in[p]};
        2'h1: {o[p], oe[p], fn[p]} = 3'b010;
        2'h2: {o[p], oe[p], fn[p]} = {diag_in[p], 2'b10};
        default: {o[p], oe[p], fn[p]} = {1'b0, fastlock_active, 1'b0};
      endcase
    end
    for (int i = 0; i < 32; i++) notes.push_back('{i, mirror[i]});
    notes.push_back('{34, {o, oe}});
    notes.push_back('{35, {4'h0, fn}});
    @(negedge sys_clk);
    -> settle;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.shift({17'h00000, a, d}, 24, 1'b1, 0);
    if (a < 15'h0020) mirror[a[4:0]] = d;
    expect_all();
  endtask

  task automatic rd(input logic [14:0] a, input int p);
    host.shift({9'h001, a, 16'h0000}, 32, 1'b1, p);
    notes.push_back('{32, mval(a)});
    notes.push_back('{33, mval(a - 15'h0001)});
    expect_all();
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    void'($urandom(32'h0ABF));
    foreach (mirror[i]) mirror[i] = 8'h00;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    expect_all();
    for (int k = 0; k < 8; k++) wr(15'($urandom_range(4, 31)), 8'($urandom));
    wr(15'h0020, 8'hA5);
    wr(15'h7FFF, 8'h5A);
    // three bytes behind one address land in descending registers
    host.shift({1'b0, 15'h0014, 24'h3C96E1}, 40, 1'b1, 0);
    {mirror[20], mirror[19], mirror[18]} = 24'h3C96E1;
    expect_all();
    // a short frame and a dropped chip enable must both leave the file alone
    host.shift({25'h0000000, 15'h0019}, 16, 1'b1, 0);
    host.shift({25'h0000000, 15'h0019}, 12, 1'b0, 0);
    host.drop_ce();
    expect_all();
    wr(15'h0019, 8'h77);
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        ext_in <= 4'($urandom);
        diag_in <= 4'($urandom);
        fastlock_active <= 1'($urandom);
        wr(15'(p), {6'h00, 2'(m)});
        if (m == 1) begin
          rd(15'($urandom_range(1, 31)), p);
          rd(15'h0000, p);
          rd(15'h0021, p);
        end
      end
    end
    wrap_up();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule
